/* File: include/dsts_pkg.sv */
/*
  constants, types and state layouts for the drive self-check sequencer.
  assumes one 100 MHz clock domain; shared by the sequencer and its synchroniser.
*/
package dsts_pkg;

  // function code sits in bits 7:5 of command byte 1
  localparam int FC_MSB = 7;
  localparam int FC_LSB = 5;
  localparam logic [2:0] FC_SHORT = 3'h1;
  localparam logic [2:0] FC_EXT = 3'h2;
  localparam logic [2:0] FC_ABORT = 3'h4;

  // four-bit result values
  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_ABORTED = 4'h1;
  localparam logic [3:0] RES_RESET = 4'h2;
  localparam logic [3:0] RES_FAIL_ELEC = 4'h3;
  localparam logic [3:0] RES_FAIL_SERVO = 4'h4;
  localparam logic [3:0] RES_FAIL_SCAN = 4'h7;
  localparam logic [3:0] RES_RUNNING = 4'hf;

  localparam int LOG_DEPTH = 20;
  localparam int LOG_IDX_W = 5;
  localparam logic [LOG_IDX_W-1:0] LOG_CNT_MAX = 5'h14;
  localparam int LBA_W = 64;

  // short test time limit
  localparam longint unsigned SHORT_LIMIT_S = 120;
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam int TIMER_W = 34;
  localparam logic [TIMER_W-1:0] SHORT_LIMIT_CYC_DEF = TIMER_W'(SHORT_LIMIT_S * CLK_HZ);

  // expected extended test length, minutes, reported to the host
  localparam logic [15:0] EXT_MINUTES_RST = 16'h005a;

  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_RUN, ST_CLOSE} dsts_st_t;
  typedef enum logic [1:0] {SEG_ELEC, SEG_SERVO, SEG_SCAN} dsts_seg_t;

  typedef struct packed {
    logic [2:0] func;
    logic [3:0] result;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] unit_code;
    logic lba_valid;
    logic [LBA_W-1:0] lba;
  } dsts_entry_t;

  typedef struct packed {
    dsts_st_t st;
    dsts_seg_t seg;
    logic [TIMER_W-1:0] timer;
    logic is_short;
    dsts_entry_t [LOG_DEPTH-1:0] log;
    logic [LOG_IDX_W-1:0] cnt;
    logic nv_store;
    logic seg_start;
    logic seg_abort;
    logic done;
    logic rst_seen;
    dsts_entry_t rd;
    logic rd_valid;
    logic [15:0] ext_min;
  } dsts_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } dsts_sync_t;

endpackage

/* File: verilog/dsts_sync.sv */
/*
  two-flop level synchroniser for one asynchronous pin.
  assumes the pin level is held for several clocks; narrower pulses may be lost.
*/
`timescale 1ns/1ns
module dsts_sync
  import dsts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_async,
  output logic pin_sync
);

  dsts_sync_t q;
  dsts_sync_t d;

  always_comb begin
    d = q;
    d.s1 = pin_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_sync = q.s2;

endmodule

/* File: verilog/dsts_sequencer.sv */
/*
  drive self-check sequencer: decodes the diagnostic function code, runs the
  three test segments through an external segment engine, keeps the 20-entry
  results log and hands each log update to non-volatile storage.
  assumes the segment engine, storage writer and command decoder share clk;
  only the bus reset pin is asynchronous.
*/
`timescale 1ns/1ns
// Operation
// RULE1 - function code bits 7:5 of byte 1: 001b short, 010b extended
// RULE2 - every test runs electrical, servo, then read/verify scan segments
// RULE3 - short test ends within 120 s, partial scan, only hard failures
// RULE4 - extended test covers seeks, on-track, read/write/read and full scan
// RULE5 - expected extended test length is readable by the host
// RULE6 - new entry goes to log head, older entries shift toward tail
// RULE7 - log holds 20 entries; the oldest drops off
// RULE8 - new entry copies function code, result Fh, then log is stored
// RULE9 - final result overwrites the entry and the log is stored again
// RULE10 - four-bit result: zero passes, non-zero gives failure reason
// RULE11 - failure records sense key, ASC, ASCQ, unit code and LBA
// RULE12 - bus reset or device reset message ends a running test
// RULE13 - abort function code ends the test with result 01
// RULE14 - any other termination records result 02
// RULE15 - host checks drive readiness before launching a test
// RULE16 - recovered errors never fail a test
// RULE17 - one-cycle done pulse when the result leaves in-progress
module dsts_sequencer
  import dsts_pkg::*;
#(
  parameter logic [TIMER_W-1:0] SHORT_LIMIT_CYC = SHORT_LIMIT_CYC_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte1,
  input wire logic drive_ready,
  input wire logic bus_reset_pin,
  input wire logic dev_reset_msg,
  output logic busy,
  output logic seg_start,
  output logic [1:0] seg_kind,
  output logic seg_partial,
  output logic seg_write_check,
  output logic seg_abort,
  input wire logic seg_done,
  input wire logic seg_fail,
  input wire logic [3:0] seg_sense_key,
  input wire logic [7:0] seg_asc,
  input wire logic [7:0] seg_ascq,
  input wire logic [7:0] seg_unit_code,
  input wire logic seg_lba_valid,
  input wire logic [LBA_W-1:0] seg_lba,
  output logic nv_store,
  input wire logic nv_ack,
  output logic test_done,
  output logic [3:0] cur_result,
  output logic [15:0] ext_test_minutes,
  input wire logic [LOG_IDX_W-1:0] log_rd_idx,
  output logic log_rd_valid,
  output logic [2:0] log_rd_func,
  output logic [3:0] log_rd_result,
  output logic [3:0] log_rd_sense_key,
  output logic [7:0] log_rd_asc,
  output logic [7:0] log_rd_ascq,
  output logic [7:0] log_rd_unit_code,
  output logic log_rd_lba_valid,
  output logic [LBA_W-1:0] log_rd_lba,
  output logic [LOG_IDX_W-1:0] log_count
);

  dsts_state_t q;
  dsts_state_t d;
  logic bus_rst_lvl;
  logic reset_ev;
  logic [2:0] fc;
  logic start_ok;
  logic abort_ok;
  logic term;
  logic [3:0] term_code;
  logic timeout;

  dsts_sync u_bus_rst_sync (
    .clk(clk),
    .rst(rst),
    .pin_async(bus_reset_pin),
    .pin_sync(bus_rst_lvl)
  );

  always_comb begin
    d = q;
    d.seg_start = 1'b0;
    d.seg_abort = 1'b0;
    d.done = 1'b0;
    d.rst_seen = bus_rst_lvl;
    reset_ev = (bus_rst_lvl & ~q.rst_seen) | dev_reset_msg;
    fc = cmd_byte1[FC_MSB:FC_LSB];
    // a launch is only taken when idle with drive_ready high, on top of the host's readiness check (see RULE15)
    start_ok = cmd_valid & drive_ready & (q.st == ST_IDLE) & ((fc == FC_SHORT) | (fc == FC_EXT)); // see RULE1
    abort_ok = cmd_valid & (fc == FC_ABORT) & ((q.st == ST_OPEN) | (q.st == ST_RUN));
    term = reset_ev | abort_ok;
    // a reset outranks an abort arriving in the same cycle
    term_code = reset_ev ? RES_RESET : RES_ABORTED; // see RULE13 see RULE14
    timeout = q.is_short & (q.timer == SHORT_LIMIT_CYC - 34'h1);
    if (log_rd_idx < q.cnt) begin
      d.rd = q.log[log_rd_idx];
      d.rd_valid = 1'b1;
    end else begin
      d.rd = '0;
      d.rd_valid = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        if (start_ok) begin
          for (int i = LOG_DEPTH - 1; i > 0; i--) begin
            d.log[i] = q.log[i-1]; // see RULE6 see RULE7
          end
          d.log[0] = '0;
          d.log[0].func = fc; // see RULE8
          d.log[0].result = RES_RUNNING;
          if (q.cnt != LOG_CNT_MAX) begin
            d.cnt = q.cnt + 5'h1; // see RULE7
          end
          d.is_short = (fc == FC_SHORT);
          d.timer = '0;
          d.nv_store = 1'b1; // see RULE8
          d.st = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (term) begin
          // store still pending, so the closing store carries the final value
          d.log[0].result = term_code; // see RULE12
          d.done = 1'b1;
          d.st = ST_CLOSE;
        end else if (nv_ack) begin
          d.nv_store = 1'b0;
          d.seg = SEG_ELEC; // see RULE2
          d.seg_start = 1'b1;
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (q.is_short) begin
          d.timer = q.timer + 34'h1;
        end
        if (term) begin
          d.seg_abort = 1'b1; // see RULE12
          d.log[0].result = term_code;
          d.nv_store = 1'b1;
          d.done = 1'b1;
          d.st = ST_CLOSE;
        end else if (seg_done & seg_fail) begin
          // seg_fail means unrecovered after all retries (see RULE16)
          case (q.seg)
            SEG_ELEC: d.log[0].result = RES_FAIL_ELEC; // see RULE10
            SEG_SERVO: d.log[0].result = RES_FAIL_SERVO;
            default: d.log[0].result = RES_FAIL_SCAN;
          endcase
          d.log[0].sense_key = seg_sense_key; // see RULE11
          d.log[0].asc = seg_asc;
          d.log[0].ascq = seg_ascq;
          d.log[0].unit_code = seg_unit_code;
          d.log[0].lba_valid = seg_lba_valid;
          d.log[0].lba = seg_lba_valid ? seg_lba : '0;
          d.nv_store = 1'b1; // see RULE9
          d.done = 1'b1; // see RULE17
          d.st = ST_CLOSE;
        end else if ((seg_done & (q.seg == SEG_SCAN)) | timeout) begin
          // the short test's running segment, whichever it is, is cut at the limit and the test passes on what it covered
          d.seg_abort = ~seg_done; // see RULE3
          d.log[0].result = RES_PASS; // see RULE10
          d.nv_store = 1'b1; // see RULE9
          d.done = 1'b1; // see RULE17
          d.st = ST_CLOSE;
        end else if (seg_done) begin
          d.seg = (q.seg == SEG_ELEC) ? SEG_SERVO : SEG_SCAN; // see RULE2
          d.seg_start = 1'b1;
        end
      end
      ST_CLOSE: begin
        if (nv_ack) begin
          d.nv_store = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ext_min <= EXT_MINUTES_RST;
    end else begin
      q <= d;
    end
  end

  assign busy = (q.st != ST_IDLE);
  assign seg_start = q.seg_start;
  assign seg_kind = q.seg;
  assign seg_partial = q.is_short; // see RULE3
  // only the extended test runs the write-element and full-surface checks
  assign seg_write_check = ~q.is_short; // see RULE4
  assign seg_abort = q.seg_abort;
  assign nv_store = q.nv_store;
  assign test_done = q.done;
  assign cur_result = q.log[0].result;
  assign ext_test_minutes = q.ext_min; // see RULE5
  assign log_rd_valid = q.rd_valid;
  assign log_rd_func = q.rd.func;
  assign log_rd_result = q.rd.result;
  assign log_rd_sense_key = q.rd.sense_key;
  assign log_rd_asc = q.rd.asc;
  assign log_rd_ascq = q.rd.ascq;
  assign log_rd_unit_code = q.rd.unit_code;
  assign log_rd_lba_valid = q.rd.lba_valid;
  assign log_rd_lba = q.rd.lba;
  assign log_count = q.cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    (q.st == ST_IDLE) && start_ok;
  endsequence

  sequence s_run_term(logic by_reset);
    (q.st == ST_RUN) && (by_reset ? reset_ev : (abort_ok && !reset_ev));
  endsequence

  sequence s_seg_ok(dsts_seg_t s);
    // a short-test timeout in the same cycle closes the test instead of advancing
    (q.st == ST_RUN) && (q.seg == s) && seg_done && !seg_fail && !term && !timeout;
  endsequence

  AST_FC_DECODE: assert property ( // see RULE1
    s_start |=> (q.log[0].func == $past(fc)) && (q.is_short == ($past(fc) == FC_SHORT))
  ) else $error("function code not decoded into new entry");

  AST_SEG_ORDER: assert property ( // see RULE2
    s_seg_ok(SEG_ELEC) |=> q.seg_start && (q.seg == SEG_SERVO)
  ) else $error("servo segment did not follow electrical");

  AST_SEG_ORDER_SCAN: assert property ( // see RULE2
    s_seg_ok(SEG_SERVO) |=> q.seg_start && (q.seg == SEG_SCAN)
  ) else $error("scan segment did not follow servo");

  AST_SHORT_LIMIT: assert property ( // see RULE3
    (q.st == ST_RUN) && q.is_short |-> (q.timer < SHORT_LIMIT_CYC)
  ) else $error("short test ran past its limit");

  AST_SCAN_MODE: assert property ( // see RULE4
    seg_start && (seg_kind == SEG_SCAN) |-> (seg_partial == (q.log[0].func == FC_SHORT))
      && (seg_write_check == (q.log[0].func == FC_EXT))
  ) else $error("scan mode does not match test kind");

  AST_LOG_SHIFT: assert property ( // see RULE6
    s_start |=> (q.log[1] == $past(q.log[0])) && (q.log[LOG_DEPTH-1] == $past(q.log[LOG_DEPTH-2]))
  ) else $error("log did not shift toward tail");

  AST_LOG_CNT: assert property ( // see RULE7
    s_start |=> q.cnt == (($past(q.cnt) == LOG_CNT_MAX) ? LOG_CNT_MAX : $past(q.cnt) + 5'h1)
  ) else $error("log count wrong after new entry");

  AST_NEW_ENTRY: assert property ( // see RULE8
    s_start |=> (q.log[0].result == RES_RUNNING) && q.nv_store && (q.st == ST_OPEN)
  ) else $error("new entry not marked running and stored");

  AST_FINAL_STORE: assert property ( // see RULE9
    q.done |-> q.nv_store && (q.st == ST_CLOSE)
  ) else $error("final result not sent to storage");

  AST_FAIL_INFO: assert property ( // see RULE11
    (q.st == ST_RUN) && seg_done && seg_fail && !term |=> (q.log[0].result != RES_PASS)
      && (q.log[0].asc == $past(seg_asc)) && (q.log[0].unit_code == $past(seg_unit_code))
  ) else $error("failure details not recorded");

  AST_RESET_END: assert property ( // see RULE12
    s_run_term(1'b1) |=> q.seg_abort && (q.st == ST_CLOSE) ##1 !q.seg_abort
  ) else $error("reset did not end the test");

  AST_ABORT_CODE: assert property ( // see RULE13
    s_run_term(1'b0) |=> (q.log[0].result == RES_ABORTED)
  ) else $error("abort not recorded as 01");

  AST_RESET_CODE: assert property ( // see RULE14
    s_run_term(1'b1) |=> (q.log[0].result == RES_RESET)
  ) else $error("reset termination not recorded as 02");

  AST_PASS: assert property ( // see RULE16
    s_seg_ok(SEG_SCAN) |=> (q.log[0].result == RES_PASS)
  ) else $error("clean scan did not pass");

  AST_DONE_PULSE: assert property ( // see RULE17
    q.done |-> ($past(q.log[0].result) == RES_RUNNING) && (q.log[0].result != RES_RUNNING)
      ##1 !q.done
  ) else $error("done pulse not tied to result change");

endmodule

/* File: bench/dsts_far_model.sv */
/*
  far-side model of the sequencer: segment engine and non-volatile store writer.
  assumes the sequencer's clk and rst; fail_kind 3 lets every segment pass.
*/
`timescale 1ns/1ns
module dsts_far_model
  import dsts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic seg_start,
  input wire logic [1:0] seg_kind,
  input wire logic seg_abort,
  input wire logic nv_store,
  input wire logic [7:0] seg_delay,
  input wire logic [1:0] fail_kind,
  output logic seg_done,
  output logic seg_fail,
  output logic [3:0] seg_sense_key,
  output logic [7:0] seg_asc,
  output logic [7:0] seg_ascq,
  output logic [7:0] seg_unit_code,
  output logic seg_lba_valid,
  output logic [LBA_W-1:0] seg_lba,
  output logic nv_ack
);
  logic act;
  logic f;
  logic [7:0] cnt;
  logic [7:0] cyc;
  logic [1:0] kind_q;
  logic [1:0] ack_cnt;
  // detail is only valid with done and fail; elsewhere it churns so stale use shows
  assign f = seg_done & seg_fail;
  assign seg_sense_key = f ? 4'h4 : cyc[3:0];
  assign seg_asc = f ? 8'h15 : cyc;
  assign seg_ascq = f ? 8'h01 : ~cyc;
  assign seg_unit_code = f ? 8'h22 : cyc;
  assign seg_lba_valid = f ? 1'b1 : cyc[0];
  assign seg_lba = f ? 64'h0000_0000_0012_3456 : {8{cyc}};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act <= 1'b0;
      cnt <= 8'h00;
      cyc <= 8'h00;
      kind_q <= 2'h0;
      ack_cnt <= 2'h0;
      seg_done <= 1'b0;
      seg_fail <= 1'b0;
      nv_ack <= 1'b0;
    end else begin
      cyc <= cyc + 8'h01;
      seg_done <= 1'b0;
      seg_fail <= 1'b0;
      nv_ack <= 1'b0;
      if (seg_start) begin
        act <= 1'b1;
        cnt <= seg_delay;
        kind_q <= seg_kind;
      end else if (seg_abort) begin
        act <= 1'b0;
      end else if (act) begin
        if (cnt <= 8'h01) begin
          act <= 1'b0;
          seg_done <= 1'b1;
          // only a fault left after all retries is reported as a failure
          seg_fail <= (kind_q == fail_kind);
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
      if (!nv_store || nv_ack) begin
        ack_cnt <= 2'h0;
      end else if (ack_cnt == 2'h2) begin
        nv_ack <= 1'b1;
      end else begin
        ack_cnt <= ack_cnt + 2'h1;
      end
    end
  end
endmodule

/* File: bench/tb.sv */
/*
  self-checking bench for the self-check sequencer with the far-side model.
  assumes a shortened short-test limit of 200 cycles.
*/
`timescale 1ns/1ns
module tb
  import dsts_pkg::*;
;
  logic clk, rst, cmd_valid, drive_ready, bus_reset_pin, dev_reset_msg;
  logic [7:0] cmd_byte1, seg_delay, seg_asc, seg_ascq, seg_unit_code;
  logic [7:0] log_rd_asc, log_rd_ascq, log_rd_unit_code;
  logic [1:0] fail_kind, seg_kind;
  logic busy, seg_start, seg_partial, seg_write_check, seg_abort, seg_done, seg_fail;
  logic [3:0] seg_sense_key, cur_result, log_rd_result, log_rd_sense_key;
  logic seg_lba_valid, nv_store, nv_ack, test_done, log_rd_valid, log_rd_lba_valid;
  logic [LBA_W-1:0] seg_lba, log_rd_lba;
  logic [15:0] ext_test_minutes;
  logic [LOG_IDX_W-1:0] log_rd_idx, log_count;
  logic [2:0] log_rd_func;
  logic [6:0] exp_q[$];
  int error_cnt, n_compared, i;

  dsts_sequencer #(.SHORT_LIMIT_CYC(TIMER_W'(200))) dut_u (.clk, .rst, .cmd_valid,
    .cmd_byte1, .drive_ready, .bus_reset_pin, .dev_reset_msg, .busy, .seg_start,
    .seg_kind, .seg_partial, .seg_write_check, .seg_abort, .seg_done, .seg_fail,
    .seg_sense_key, .seg_asc, .seg_ascq, .seg_unit_code, .seg_lba_valid, .seg_lba,
    .nv_store, .nv_ack, .test_done, .cur_result, .ext_test_minutes, .log_rd_idx,
    .log_rd_valid, .log_rd_func, .log_rd_result, .log_rd_sense_key, .log_rd_asc,
    .log_rd_ascq, .log_rd_unit_code, .log_rd_lba_valid, .log_rd_lba, .log_count);

  dsts_far_model far_u (.clk, .rst, .seg_start, .seg_kind, .seg_abort, .nv_store,
    .seg_delay, .fail_kind, .seg_done, .seg_fail, .seg_sense_key, .seg_asc, .seg_ascq,
    .seg_unit_code, .seg_lba_valid, .seg_lba, .nv_ack);

  always #5 clk = ~clk;

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task cmd(input logic [2:0] fc);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte1 = {fc, 5'h00};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task rd(input logic [4:0] idx);
    @(negedge clk);
    log_rd_idx = idx;
    repeat (2) @(negedge clk);
  endtask

  // mode 0 runs to the end, 1 aborts, 2 reset message, 3 bus reset pin,
  // 4 aborts before the first store is acknowledged
  task run_test(input logic [2:0] fc, input int mode, input logic [3:0] exp,
                input logic [5:0] exp_seq, input logic exp_ab);
    logic [5:0] seq;
    int ab;
    int k;
    seq = 6'h3f;
    ab = 0;
    cmd(fc);
    chk(busy, 1'b1);
    chk(cur_result, RES_RUNNING);
    chk(nv_store, 1'b1);
    for (k = 0; k < 2000; k++) begin
      @(negedge clk);
      if (seg_start === 1'b1) begin
        seq = {seq[3:0], seg_kind};
        chk(seg_partial, fc == FC_SHORT);
        chk(seg_write_check, fc == FC_EXT);
      end
      if (seg_abort === 1'b1) ab++;
      if ((k == 30 && mode == 1) || (k == 0 && mode == 4)) begin
        cmd_valid = 1'b1;
        cmd_byte1 = {FC_ABORT, 5'h00};
      end
      if (k == 30 && mode == 2) dev_reset_msg = 1'b1;
      if (k == 30 && mode == 3) bus_reset_pin = 1'b1;
      if (k == 31 || k == 1) begin
        cmd_valid = 1'b0;
        dev_reset_msg = 1'b0;
      end
      if (test_done === 1'b1) break;
    end
    bus_reset_pin = 1'b0;
    chk(k < 2000, 1'b1);
    chk(cur_result, exp);
    chk(seq, exp_seq);
    chk(ab, exp_ab);
    @(negedge clk);
    chk(test_done, 1'b0);
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
    chk(busy, 1'b0);
    exp_q.push_front({fc, exp});
    if (exp_q.size() > LOG_DEPTH) exp_q.pop_back();
  endtask

  initial begin
    #200000;
    error_cnt++;
    final_report;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte1 = 8'h00;
    drive_ready = 1'b1;
    bus_reset_pin = 1'b0;
    dev_reset_msg = 1'b0;
    log_rd_idx = '0;
    seg_delay = 8'h14;
    fail_kind = 2'h3;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(ext_test_minutes, EXT_MINUTES_RST);
    chk(log_count, 0);
    run_test(FC_SHORT, 0, RES_PASS, 6'h06, 1'b0);
    chk(log_count, 1);
    fail_kind = 2'h1;
    run_test(FC_EXT, 0, RES_FAIL_SERVO, 6'h31, 1'b0);
    rd(5'd0);
    chk({log_rd_sense_key, log_rd_asc, log_rd_ascq, log_rd_unit_code}, 28'h4150122);
    chk({log_rd_lba_valid, log_rd_lba[62:0]}, 64'h8000_0000_0012_3456);
    fail_kind = 2'h3;
    run_test(FC_EXT, 1, RES_ABORTED, 6'h31, 1'b1);
    run_test(FC_SHORT, 2, RES_RESET, 6'h31, 1'b1);
    run_test(FC_EXT, 3, RES_RESET, 6'h31, 1'b1);
    seg_delay = 8'h50;
    run_test(FC_SHORT, 0, RES_PASS, 6'h06, 1'b1);
    // launches that must be ignored: drive not ready, unknown code, abort when idle
    drive_ready = 1'b0;
    cmd(FC_EXT);
    drive_ready = 1'b1;
    cmd(3'h3);
    cmd(FC_ABORT);
    @(negedge clk);
    chk(busy, 1'b0);
    chk(log_count, 6);
    seg_delay = 8'h02;
    run_test(FC_SHORT, 4, RES_ABORTED, 6'h3f, 1'b0);
    fail_kind = 2'h0;
    run_test(FC_SHORT, 0, RES_FAIL_ELEC, 6'h3c, 1'b0);
    fail_kind = 2'h2;
    run_test(FC_EXT, 0, RES_FAIL_SCAN, 6'h06, 1'b0);
    fail_kind = 2'h3;
    for (i = 0; i < 16; i++) run_test(i[0] ? FC_EXT : FC_SHORT, 0, RES_PASS, 6'h06, 1'b0);
    chk(log_count, LOG_DEPTH);
    for (i = 0; i < LOG_DEPTH; i++) begin
      rd(i[4:0]);
      chk({log_rd_valid, log_rd_func, log_rd_result}, {1'b1, exp_q[i]});
    end
    rd(5'd20);
    chk(log_rd_valid, 1'b0);
    final_report;
  end
endmodule
